// ---- hdl/icc_pkg.sv ----
`default_nettype none
package icc_pkg;
    // =========================================
    // Register port indices (device side)
    localparam logic [1:0] ICC_IDX_GLOBAL = 2'h0;
    localparam logic [1:0] ICC_IDX_FLUSH_LO = 2'h1;
    localparam logic [1:0] ICC_IDX_FLUSH_HI = 2'h2;
    localparam logic [1:0] ICC_IDX_WAYCTL = 2'h3;
    // =========================================
    // Global control field positions
    localparam int ICC_GC_ENABLE_ALL = 0;
    localparam int ICC_GC_FILL_MODE = 1;
    localparam int ICC_GC_FORWARD = 2;
    localparam int ICC_GC_WAYSEL_LO = 3;
    localparam int ICC_GC_WAYSEL_HI = 4;
    localparam int ICC_GC_RSSEL_LO = 5;
    localparam int ICC_GC_RSSEL_HI = 8;
    localparam int ICC_GC_WAY_PRES = 9;
    localparam int ICC_GC_RS_PRES = 10;
    localparam int ICC_GC_FLUSH_ALL = 11;
    localparam logic [15:0] ICC_GC_MASK = 16'h0FFF;
    localparam logic [15:0] ICC_GC_RESET = 16'h0000;
    // =========================================
    // Line flush address fields
    localparam logic [15:0] ICC_FLHI_MASK = 16'h00FF;
    localparam logic [15:0] ICC_FL_RESET = 16'h0000;
    // =========================================
    // Way block control fields
    localparam int ICC_WC_ENABLE = 0;
    localparam int ICC_WC_FLUSH = 1;
    localparam int ICC_WC_SIZE_LO = 2;
    localparam int ICC_WC_SIZE_HI = 4;
    localparam logic [2:0] ICC_WAY_SIZE_8K = 3'h3;
    localparam logic [15:0] ICC_WC_MASK = 16'h001F;
    localparam logic [15:0] ICC_WC_RESET = 16'h000D;
    localparam logic [15:0] ICC_WC_REQUIRED = 16'h000F;
    // =========================================
    // Controller Wishbone byte offsets
    localparam logic [3:0] ICC_WB_CONFIG = 4'h0;
    localparam logic [3:0] ICC_WB_CONTROL = 4'h4;
    localparam logic [3:0] ICC_WB_STATUS = 4'h8;
    localparam logic [3:0] ICC_WB_FLUSHADDR = 4'hC;
    localparam int ICC_CTL_ENABLE = 0;
    localparam int ICC_CTL_CLEAR = 1;
    localparam int ICC_ST_READY = 0;
    localparam int ICC_ST_BUSY = 1;
    localparam int ICC_ST_GCR_LO = 16;
    // =========================================
    // Line fill defaults
    localparam int ICC_LINE_WORDS = 4;
    localparam int ICC_ADDR_W = 24;
    localparam int ICC_DATA_W = 32;
endpackage
`default_nettype wire

// ---- hdl/icc_link_if.sv ----
`default_nettype none
interface icc_link_if;
    logic regSel;
    logic regWr;
    logic [1:0] regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic regAck;
    logic core_cache_enable;
    logic core_cache_clear;
    modport device (
        input regSel, regWr, regAddr, regWdata, core_cache_enable, core_cache_clear,
        output regRdata, regAck
    );
    modport host (
        output regSel, regWr, regAddr, regWdata, core_cache_enable, core_cache_clear,
        input regRdata, regAck
    );
endinterface
`default_nettype wire

// ---- hdl/icc_device.sv ----
`default_nettype none
// Notes on behaviour
// - Ramset count bit0 selects block 2
// - Way count bit low selects two ways
// - Miss loads line, forwards word early
// - Software always writes forwarding bit one
// - Software always writes fill mode one
// - Override clear: local enables gate blocks
// - Override set: enable ignores local bits
// - Lower flush register holds sixteen bits
// - Upper flush register: bits 15-8 zero
// - Flush address registers change no contents
// - Way control programmed before enable
// - Way size always programmed 8KB
// - Way local flush bit written one
// - Way local enable bit written one
// - Ramset presence bit enables ramset blocks
// - Way_block_present bit enables way block
// - Global flush ignores local flush bits
module icc_device
    import icc_pkg::*;
#(
    parameter int LINE_WORDS = ICC_LINE_WORDS,
    parameter int ADDR_W = ICC_ADDR_W,
    parameter int DATA_W = ICC_DATA_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link to controller
    icc_link_if.device link,
    // Ramset local bits
    input wire logic [1:0] ramsetLocalEnable,
    input wire logic [1:0] ramsetLocalFlush,
    // Block enables and flushes
    output logic wayEnable,
    output logic wayTwoWay,
    output logic [1:0] ramsetEnable,
    output logic wayFlush,
    output logic [1:0] ramsetFlush,
    output logic [2:0] waySizeSel,
    // Core fetch miss
    input wire logic missReq,
    input wire logic [ADDR_W-1:0] missAddr,
    output logic missBusy,
    output logic fwdValid,
    output logic [DATA_W-1:0] fwdData,
    // External memory line load
    output logic memReq,
    output logic [ADDR_W-1:0] memAddr,
    input wire logic memValid,
    input wire logic [DATA_W-1:0] memData
);
    localparam int OFS_W = (LINE_WORDS > 1) ? $clog2(LINE_WORDS) : 1;

    typedef enum logic [1:0] {
        ICC_FILL_IDLE = 2'b00,
        ICC_FILL_LOAD = 2'b01,
        ICC_FILL_LATE = 2'b10
    } icc_fill_t;

    typedef struct packed {
        logic [15:0] globalCtl;
        logic [15:0] flushLo;
        logic [15:0] flushHi;
        logic [15:0] wayCtl;
        logic [15:0] rdata;
        logic ack;
        logic wayEn;
        logic twoWay;
        logic [1:0] rsEn;
        logic wayFl;
        logic [1:0] rsFl;
        icc_fill_t fill;
        logic [OFS_W-1:0] wantOfs;
        logic [OFS_W-1:0] gotOfs;
        logic [ADDR_W-1:0] lineAddr;
        logic req;
        logic fwd;
        logic [DATA_W-1:0] word;
        logic busy;
    } icc_dev_state_t;

    icc_dev_state_t st_r;
    icc_dev_state_t st_nxt;

    logic streamOn;
    logic enableAll;
    logic flushAll;
    logic lastWord;
    logic [ADDR_W-1:0] lineBase;

    // =========================================
    // Decode of the held settings
    assign streamOn = st_r.globalCtl[ICC_GC_FORWARD];
    assign enableAll = st_r.globalCtl[ICC_GC_ENABLE_ALL];
    assign flushAll = st_r.globalCtl[ICC_GC_FLUSH_ALL];
    assign lastWord = (st_r.gotOfs == OFS_W'(LINE_WORDS - 1));
    assign lineBase = {missAddr[ADDR_W-1:OFS_W], {OFS_W{1'b0}}};

    // =========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.fwd = 1'b0;

        // Register port: one access per select, ack drops after one cycle
        if (link.regSel && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            if (link.regWr) begin
                case (link.regAddr)
                    ICC_IDX_GLOBAL: st_nxt.globalCtl = link.regWdata & ICC_GC_MASK;
                    ICC_IDX_FLUSH_LO: st_nxt.flushLo = link.regWdata;
                    ICC_IDX_FLUSH_HI: st_nxt.flushHi = link.regWdata & ICC_FLHI_MASK;
                    ICC_IDX_WAYCTL: st_nxt.wayCtl = link.regWdata & ICC_WC_MASK;
                    default: st_nxt.wayCtl = st_r.wayCtl;
                endcase
            end
            case (link.regAddr)
                ICC_IDX_GLOBAL: st_nxt.rdata = st_r.globalCtl;
                ICC_IDX_FLUSH_LO: st_nxt.rdata = st_r.flushLo;
                ICC_IDX_FLUSH_HI: st_nxt.rdata = st_r.flushHi & ICC_FLHI_MASK;
                ICC_IDX_WAYCTL: st_nxt.rdata = st_r.wayCtl;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end

        // Enables follow the core level under the current settings
        st_nxt.wayEn = link.core_cache_enable && st_r.globalCtl[ICC_GC_WAY_PRES]
            && (enableAll || st_r.wayCtl[ICC_WC_ENABLE]);
        st_nxt.twoWay = st_r.globalCtl[ICC_GC_WAYSEL_LO];
        st_nxt.rsEn[0] = link.core_cache_enable && st_r.globalCtl[ICC_GC_RS_PRES]
            && (enableAll || ramsetLocalEnable[0]);
        st_nxt.rsEn[1] = link.core_cache_enable && st_r.globalCtl[ICC_GC_RS_PRES]
            && st_r.globalCtl[ICC_GC_RSSEL_LO]
            && (enableAll || ramsetLocalEnable[1]);

        // Flush levels; flush address registers take no part
        st_nxt.wayFl = link.core_cache_clear && st_r.globalCtl[ICC_GC_WAY_PRES]
            && (flushAll || st_r.wayCtl[ICC_WC_FLUSH]);
        st_nxt.rsFl[0] = link.core_cache_clear && st_r.globalCtl[ICC_GC_RS_PRES]
            && (flushAll || ramsetLocalFlush[0]);
        st_nxt.rsFl[1] = link.core_cache_clear && st_r.globalCtl[ICC_GC_RS_PRES]
            && st_r.globalCtl[ICC_GC_RSSEL_LO] && (flushAll || ramsetLocalFlush[1]);

        // Line fill with early forwarding of the missed word
        case (st_r.fill)
            ICC_FILL_IDLE: begin
                if (missReq) begin
                    st_nxt.fill = ICC_FILL_LOAD;
                    st_nxt.req = 1'b1;
                    st_nxt.lineAddr = lineBase;
                    st_nxt.wantOfs = missAddr[OFS_W-1:0];
                    st_nxt.gotOfs = '0;
                end
            end
            ICC_FILL_LOAD: begin
                if (memValid) begin
                    st_nxt.lineAddr = st_r.lineAddr + ADDR_W'(1);
                    st_nxt.gotOfs = st_r.gotOfs + OFS_W'(1);
                    if (st_r.gotOfs == st_r.wantOfs) begin
                        st_nxt.word = memData;
                        st_nxt.fwd = streamOn;
                    end
                    if (lastWord) begin
                        st_nxt.req = 1'b0;
                        // Without forwarding the word waits for the full line
                        st_nxt.fill = streamOn ? ICC_FILL_IDLE : ICC_FILL_LATE;
                    end
                end
            end
            ICC_FILL_LATE: begin
                st_nxt.fwd = 1'b1;
                st_nxt.fill = ICC_FILL_IDLE;
            end
            default: st_nxt.fill = ICC_FILL_IDLE;
        endcase
        // Busy kept in a flop so the output needs no decode
        st_nxt.busy = (st_nxt.fill != ICC_FILL_IDLE);
    end

    // =========================================
    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.globalCtl <= ICC_GC_RESET;
            st_r.flushLo <= ICC_FL_RESET;
            st_r.flushHi <= ICC_FL_RESET;
            st_r.wayCtl <= ICC_WC_RESET;
            st_r.fill <= ICC_FILL_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================
    // Outputs
    assign link.regRdata = st_r.rdata;
    assign link.regAck = st_r.ack;
    assign wayEnable = st_r.wayEn;
    assign wayTwoWay = st_r.twoWay;
    assign ramsetEnable = st_r.rsEn;
    assign wayFlush = st_r.wayFl;
    assign ramsetFlush = st_r.rsFl;
    assign waySizeSel = st_r.wayCtl[ICC_WC_SIZE_HI:ICC_WC_SIZE_LO];
    assign missBusy = st_r.busy;
    assign fwdValid = st_r.fwd;
    assign fwdData = st_r.word;
    assign memReq = st_r.req;
    assign memAddr = st_r.lineAddr;
endmodule
`default_nettype wire

// ---- hdl/icc_host.sv ----
`default_nettype none
module icc_host
    import icc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link to device
    icc_link_if.host link
);
    typedef enum logic [2:0] {
        ICC_SEQ_IDLE = 3'b000,
        ICC_SEQ_GCR = 3'b001,
        ICC_SEQ_FLO = 3'b010,
        ICC_SEQ_FHI = 3'b011,
        ICC_SEQ_WAY = 3'b100,
        ICC_SEQ_READ = 3'b101,
        ICC_SEQ_ON = 3'b110
    } icc_seq_t;

    typedef struct packed {
        logic [15:0] cfgImage;
        logic [23:0] flushAddr;
        logic [1:0] control;
        logic [15:0] gcrSeen;
        logic ready;
        icc_seq_t seq;
        logic sel;
        logic wr;
        logic [1:0] addr;
        logic [15:0] wdata;
        logic enable;
        logic clear;
        logic ack;
        logic [31:0] dat;
    } icc_host_state_t;

    icc_host_state_t st_r;
    icc_host_state_t st_nxt;
    logic wbReq;

    assign wbReq = wb_cyc_i && wb_stb_i && !st_r.ack;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        // =========================================
        // Wishbone register file
        if (wbReq) begin
            st_nxt.ack = 1'b1;
            if (wb_we_i && wb_sel_i[0]) begin
                case (wb_adr_i)
                    ICC_WB_CONFIG: st_nxt.cfgImage = wb_dat_i[15:0];
                    ICC_WB_CONTROL: st_nxt.control = wb_dat_i[1:0];
                    ICC_WB_FLUSHADDR: st_nxt.flushAddr = wb_dat_i[23:0];
                    default: st_nxt.control = st_r.control;
                endcase
            end
            case (wb_adr_i)
                ICC_WB_CONFIG: st_nxt.dat = {16'h0000, st_r.cfgImage};
                ICC_WB_CONTROL: st_nxt.dat = {30'h0, st_r.control};
                ICC_WB_STATUS: st_nxt.dat = {st_r.gcrSeen, 14'h0, st_r.seq != ICC_SEQ_IDLE && !st_r.enable,
                    st_r.ready};
                ICC_WB_FLUSHADDR: st_nxt.dat = {8'h00, st_r.flushAddr};
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end
        st_nxt.clear = st_r.control[ICC_CTL_CLEAR];
        // =========================================
        // Programming sequence, one link access at a time
        if (link.regAck) begin
            st_nxt.sel = 1'b0;
        end
        case (st_r.seq)
            ICC_SEQ_IDLE: begin
                st_nxt.enable = 1'b0;
                if (st_r.control[ICC_CTL_ENABLE]) begin
                    st_nxt.seq = ICC_SEQ_GCR;
                    st_nxt.sel = 1'b1;
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = ICC_IDX_GLOBAL;
                    st_nxt.wdata = st_r.cfgImage & ICC_GC_MASK;
                    st_nxt.wdata[ICC_GC_FORWARD] = 1'b1;
                    st_nxt.wdata[ICC_GC_FILL_MODE] = 1'b1;
                end
            end
            ICC_SEQ_GCR: if (link.regAck) begin
                // Written for completeness; the device stores them but no flush uses them
                st_nxt.seq = ICC_SEQ_FLO;
                st_nxt.sel = 1'b1;
                st_nxt.addr = ICC_IDX_FLUSH_LO;
                st_nxt.wdata = st_r.flushAddr[15:0];
            end
            ICC_SEQ_FLO: if (link.regAck) begin
                st_nxt.seq = ICC_SEQ_FHI;
                st_nxt.sel = 1'b1;
                st_nxt.addr = ICC_IDX_FLUSH_HI;
                st_nxt.wdata = {8'h00, st_r.flushAddr[23:16]};
            end
            ICC_SEQ_FHI: if (link.regAck) begin
                st_nxt.seq = ICC_SEQ_WAY;
                st_nxt.sel = 1'b1;
                st_nxt.addr = ICC_IDX_WAYCTL;
                st_nxt.wdata = ICC_WC_REQUIRED;
            end
            ICC_SEQ_WAY: if (link.regAck) begin
                st_nxt.seq = ICC_SEQ_READ;
                st_nxt.sel = 1'b1;
                st_nxt.wr = 1'b0;
                st_nxt.addr = ICC_IDX_GLOBAL;
            end
            ICC_SEQ_READ: if (link.regAck) begin
                st_nxt.gcrSeen = link.regRdata;
                st_nxt.ready = 1'b1;
                st_nxt.enable = 1'b1;
                st_nxt.seq = ICC_SEQ_ON;
            end
            ICC_SEQ_ON: begin
                if (!st_r.control[ICC_CTL_ENABLE]) begin
                    st_nxt.enable = 1'b0;
                    st_nxt.ready = 1'b0;
                    st_nxt.seq = ICC_SEQ_IDLE;
                end
            end
            default: st_nxt.seq = ICC_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.seq <= ICC_SEQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign link.regSel = st_r.sel;
    assign link.regWr = st_r.wr;
    assign link.regAddr = st_r.addr;
    assign link.regWdata = st_r.wdata;
    assign link.core_cache_enable = st_r.enable;
    assign link.core_cache_clear = st_r.clear;
endmodule
`default_nettype wire

// ---- testbench/icc_checker.sv ----
`default_nettype none
module icc_checker
    import icc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link
    input wire logic regSel,
    input wire logic regWr,
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regAck,
    input wire logic core_cache_enable,
    input wire logic core_cache_clear,
    // Device blocks
    input wire logic [1:0] ramsetLocalEnable,
    input wire logic wayEnable,
    input wire logic [1:0] ramsetEnable,
    input wire logic wayFlush
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Shadow of link writes
    logic [11:0] gcr_r;
    logic wcEn_r;
    logic wcDone_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gcr_r <= ICC_GC_RESET[11:0];
            wcEn_r <= ICC_WC_RESET[ICC_WC_ENABLE];
            wcDone_r <= 1'b0;
        end else if (regSel && regWr && regAck) begin
            if (regAddr == ICC_IDX_GLOBAL) begin
                gcr_r <= regWdata[11:0];
            end
            if (regAddr == ICC_IDX_WAYCTL) begin
                wcEn_r <= regWdata[ICC_WC_ENABLE];
                wcDone_r <= 1'b1;
            end
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence sGlobalWr;
        regSel && regWr && regAck && regAddr == ICC_IDX_GLOBAL;
    endsequence
    sequence sWayWr;
        regSel && regWr && regAck && regAddr == ICC_IDX_WAYCTL;
    endsequence
    sequence sEnRise;
        !core_cache_enable ##1 core_cache_enable;
    endsequence
    a_forward_bit_set: assert property (sGlobalWr |-> regWdata[ICC_GC_FORWARD])
        else $error("forwarding bit written as zero");
    a_fill_mode_set: assert property (sGlobalWr |-> regWdata[ICC_GC_FILL_MODE])
        else $error("fill mode bit written as zero");
    a_way_size_8k: assert property (sWayWr |-> regWdata[ICC_WC_SIZE_HI:ICC_WC_SIZE_LO] == ICC_WAY_SIZE_8K)
        else $error("way size not 8KB");
    a_way_local_bits: assert property (sWayWr |-> regWdata[ICC_WC_FLUSH] && regWdata[ICC_WC_ENABLE])
        else $error("way local flush or enable written zero");
    a_ctl_before_enable: assert property (sEnRise |-> wcDone_r)
        else $error("cache enabled before way control was written");
    a_way_enable_rule: assert property (wayEnable == $past(core_cache_enable && gcr_r[ICC_GC_WAY_PRES]
        && (gcr_r[ICC_GC_ENABLE_ALL] || wcEn_r))) else $error("way enable wrong");
    a_ramset_enable_rule: assert property (ramsetEnable == $past({
        core_cache_enable && gcr_r[ICC_GC_RS_PRES] && gcr_r[ICC_GC_RSSEL_LO] && (gcr_r[0] || ramsetLocalEnable[1]),
        core_cache_enable && gcr_r[ICC_GC_RS_PRES] && (gcr_r[0] || ramsetLocalEnable[0])}))
        else $error("ramset enable wrong");
    a_global_flush: assert property ($past(core_cache_clear && gcr_r[ICC_GC_FLUSH_ALL] && gcr_r[9]) |-> wayFlush)
        else $error("global flush missed way block");
endmodule
`default_nettype wire

// ---- testbench/test_icache_config_control.sv ----
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module test_icache_config_control
    import icc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [11:0] cfg;
        logic [1:0] ctl;
        logic [1:0] loc;
        logic way;
        logic two;
        logic [1:0] rs;
        logic wfl;
        logic [1:0] rfl;
    } icc_row_t;
    // ==========
    // Signals
    logic clock, rst, wbCyc, wbStb, wbWe, wbAck;
    logic [3:0] wbAdr, wbSel;
    logic [31:0] wbDatI, wbDatO, fwdData, memData;
    logic [1:0] ramsetLocalEnable, ramsetLocalFlush, ramsetEnable, ramsetFlush;
    logic wayEnable, wayTwoWay, wayFlush, missReq, missBusy, fwdValid, memReq, memValid;
    logic [2:0] waySizeSel;
    logic [23:0] missAddr, memAddr;
    logic [15:0] flLo, flHi;
    int failures, checked;
    // Cfg, ctl, local enables, way, two-way, ramsets, way flush, ramset flush
    icc_row_t rows[8] = '{
        '{12'h200, 2'b11, 2'b00, 1'b1, 1'b0, 2'b00, 1'b1, 2'b00},
        '{12'h208, 2'b11, 2'b00, 1'b1, 1'b1, 2'b00, 1'b1, 2'b00},
        '{12'h601, 2'b11, 2'b00, 1'b1, 1'b0, 2'b01, 1'b1, 2'b00},
        '{12'h621, 2'b11, 2'b00, 1'b1, 1'b0, 2'b11, 1'b1, 2'b00},
        '{12'h620, 2'b11, 2'b10, 1'b1, 1'b0, 2'b10, 1'b1, 2'b00},
        '{12'h420, 2'b01, 2'b01, 1'b0, 1'b0, 2'b01, 1'b0, 2'b00},
        '{12'h620, 2'b01, 2'b11, 1'b1, 1'b0, 2'b11, 1'b0, 2'b00},
        '{12'hE21, 2'b11, 2'b00, 1'b1, 1'b0, 2'b11, 1'b1, 2'b11}};
    icc_link_if link();
    icc_host i_icc_host(.clock(clock), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .link(link.host));
    icc_device i_icc_device(.clock(clock), .rst(rst), .link(link.device), .ramsetLocalEnable(ramsetLocalEnable),
        .ramsetLocalFlush(ramsetLocalFlush), .wayEnable(wayEnable), .wayTwoWay(wayTwoWay),
        .ramsetEnable(ramsetEnable), .wayFlush(wayFlush), .ramsetFlush(ramsetFlush), .waySizeSel(waySizeSel),
        .missReq(missReq), .missAddr(missAddr), .missBusy(missBusy), .fwdValid(fwdValid), .fwdData(fwdData),
        .memReq(memReq), .memAddr(memAddr), .memValid(memValid), .memData(memData));
    icc_checker i_icc_checker(.clock(clock), .rst(rst), .regSel(link.regSel), .regWr(link.regWr),
        .regAddr(link.regAddr), .regWdata(link.regWdata), .regAck(link.regAck),
        .core_cache_enable(link.core_cache_enable), .core_cache_clear(link.core_cache_clear),
        .ramsetLocalEnable(ramsetLocalEnable), .wayEnable(wayEnable), .ramsetEnable(ramsetEnable),
        .wayFlush(wayFlush));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Flush address as it crosses the link
    always @(posedge clock) begin
        if (link.regSel && link.regWr && link.regAck && link.regAddr == ICC_IDX_FLUSH_LO) flLo <= link.regWdata;
        if (link.regSel && link.regWr && link.regAck && link.regAddr == ICC_IDX_FLUSH_HI) flHi <= link.regWdata;
    end
    // ==========
    // Tasks
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        wbSel <= 4'hF;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (wbAck === 1'b1) break;
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n == 50) begin
            failures++;
            summarize();
        end
        @(posedge clock);
    endtask
    // Only the host's own sequence decides when enable moves
    task automatic waitEn(input logic v);
        int n;
        for (n = 0; n < 100; n++) begin
            if (link.core_cache_enable === v) break;
            @(posedge clock);
        end
        if (n == 100) begin
            failures++;
            summarize();
        end
    endtask
    // ==========
    // Sequence
    initial begin
        logic [31:0] rd;
        logic [31:0] got;
        logic seen;
        logic early;
        int n;
        failures = 0;
        checked = 0;
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, missReq, memValid} = 5'h00;
        {wbAdr, wbSel, wbDatI, memData, missAddr} = '0;
        ramsetLocalEnable = 2'h0;
        ramsetLocalFlush = 2'h0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wb(1'b1, ICC_WB_FLUSHADDR, 32'h00ABCDEF, rd);
        foreach (rows[i]) begin
            wb(1'b1, ICC_WB_CONTROL, 32'h0, rd);
            waitEn(1'b0);
            wb(1'b1, ICC_WB_CONFIG, {20'h0, rows[i].cfg}, rd);
            ramsetLocalEnable <= rows[i].loc;
            wb(1'b1, ICC_WB_CONTROL, {30'h0, rows[i].ctl}, rd);
            waitEn(1'b1);
            repeat (3) @(posedge clock);
            `CHK("wayEnable", rows[i].way, wayEnable)
            `CHK("wayTwoWay", rows[i].two, wayTwoWay)
            `CHK("ramsetEnable", rows[i].rs, ramsetEnable)
            `CHK("wayFlush", rows[i].wfl, wayFlush)
            `CHK("ramsetFlush", rows[i].rfl, ramsetFlush)
            `CHK("waySizeSel", ICC_WAY_SIZE_8K, waySizeSel)
            wb(1'b0, ICC_WB_STATUS, 32'h0, rd);
            `CHK("gcr readback", {4'h0, rows[i].cfg | 12'h006}, rd[31:16])
            `CHK("status ready", 2'b01, rd[1:0])
        end
        `CHK("flush low", 16'hCDEF, flLo)
        `CHK("flush high", 8'hAB, flHi[7:0])
        `CHK("flush low reg", 16'hCDEF, i_icc_device.st_r.flushLo)
        `CHK("flush high reg", 16'h00AB, i_icc_device.st_r.flushHi)
        wb(1'b0, 4'h2, 32'h0, rd);
        `CHK("unmapped read", 32'h0, rd)
        // Miss at word 2 of a line: word must come out before the line ends
        missAddr <= 24'h000102;
        missReq <= 1'b1;
        @(posedge clock);
        missReq <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (memReq === 1'b1) break;
        end
        if (n == 50) begin
            failures++;
            summarize();
        end
        `CHK("memAddr", 24'h000100, memAddr)
        `CHK("missBusy load", 1'b1, missBusy)
        seen = 1'b0;
        got = 32'h0;
        early = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (fwdValid === 1'b1 && !seen) begin
                seen = 1'b1;
                got = fwdData;
                early = memReq;
            end
            memValid <= (i < 4);
            memData <= 32'hD0 + 32'(i);
            @(posedge clock);
        end
        `CHK("fwd seen", 1'b1, seen)
        `CHK("fwdData", 32'hD2, got)
        `CHK("fwd early", 1'b1, early)
        `CHK("missBusy idle", 1'b0, missBusy)
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("reset wayEnable", 1'b0, wayEnable)
        `CHK("reset ramsetEnable", 2'b00, ramsetEnable)
        `CHK("reset enable", 1'b0, link.core_cache_enable)
        rst <= 1'b0;
        @(posedge clock);
        wb(1'b0, ICC_WB_STATUS, 32'h0, rd);
        `CHK("reset readback", 16'h0000, rd[31:16])
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
